// >>> pin_function_select_pkg.sv
// Constants, field layouts and carrier types for the pin function select block
package pin_function_select_pkg;

    // ----------------------------------------------------------------
    // Register offsets and reset values
    // ----------------------------------------------------------------
    localparam int          ADDR_W                  = 16;
    localparam logic [15:0] SERIAL_ROLE_SWITCH_OFS  = 16'h018C;
    localparam logic [15:0] INTERRUPT_PIN_ROUTE_OFS = 16'h018E;
    localparam logic [15:0] IO_FUNCTION_ROUTE_OFS   = 16'h018F;
    localparam logic [7:0]  SERIAL_ROLE_SWITCH_RST  = 8'h00;
    localparam logic [7:0]  INTERRUPT_PIN_ROUTE_RST = 8'h00;
    localparam logic [7:0]  IO_FUNCTION_ROUTE_RST   = 8'h00;

    // Bits that hold state; all others ignore writes and read zero
    localparam logic [7:0]  SERIAL_ROLE_SWITCH_MASK  = 8'h01;
    localparam logic [7:0]  INTERRUPT_PIN_ROUTE_MASK = 8'h0E;
    localparam logic [7:0]  IO_FUNCTION_ROUTE_MASK   = 8'hF8;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int SERIAL_ROLE_SELECT_POS = 0;
    localparam int IRQ_ROUTE_LSB          = 1;
    localparam int IRQ_ROUTE_MSB          = 3;
    localparam int PORT_READ_SOURCE_POS   = 3;
    localparam int TWI_RATE_DOUBLE_POS    = 4;
    localparam int TWI_RATE_HALF_POS      = 5;
    localparam int DATA_DELAY_LSB         = 6;
    localparam int DATA_DELAY_MSB         = 7;

    // ----------------------------------------------------------------
    // Codes and counts
    // ----------------------------------------------------------------
    localparam logic [2:0] IRQ_FROM_P1_7   = 3'h0;
    localparam logic [2:0] IRQ_FROM_P1_5   = 3'h1;
    localparam logic [2:0] IRQ_FROM_P2_0   = 3'h2;
    localparam logic [1:0] DELAY_CODE_SHORT = 2'h0;
    localparam logic [1:0] DELAY_CODE_MID   = 2'h1;
    localparam int SDA_DELAY_SHORT = 3;
    localparam int SDA_DELAY_MID   = 11;
    localparam int SDA_DELAY_LONG  = 19;
    localparam int PORT_COUNT      = 5;
    localparam int PORT_WIDTH      = 8;
    localparam int EXEMPT_PORT     = 4;
    localparam int EXEMPT_BIT      = 2;
    localparam int TWI_SDA_IDX     = 1;

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } reg_req_type;

    typedef struct packed {
        logic out;
        logic oe_n;
    } pin_drive_type;

    localparam pin_drive_type PIN_RELEASED = '{out: 1'b1, oe_n: 1'b1};

    // Cycles of delay for a code; the forbidden code falls on the longest
    function automatic int sda_delay_cycles(input logic [1:0] code);
        if (code == DELAY_CODE_SHORT) begin
            return SDA_DELAY_SHORT;
        end else if (code == DELAY_CODE_MID) begin
            return SDA_DELAY_MID;
        end
        return SDA_DELAY_LONG;
    endfunction

endpackage

// >>> sda_delay_line.sv
// Selectable digital delay line for the data line drive
`timescale 1ns/1ps
module sda_delay_line
    import pin_function_select_pkg::*;
#(
    parameter int DEPTH = SDA_DELAY_LONG
) (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          reset,
    // Drive in, code, drive out
    input  wire pin_drive_type din,
    input  wire logic [1:0]    code,
    output pin_drive_type      dout
);

    pin_drive_type shift_ff [0:DEPTH-2];
    logic [4:0]    tap;

    // Tap k is k+1 cycles late; the caller's output flop adds the last one
    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                shift_ff[i] <= PIN_RELEASED;
            end
        end else begin
            shift_ff[0] <= din;
            for (int i = 1; i < DEPTH - 1; i++) begin
                shift_ff[i] <= shift_ff[i-1];
            end
        end
    end

    assign tap  = 5'(sda_delay_cycles(code) - 2);
    assign dout = shift_ff[tap];

endmodule

// >>> pin_function_select.sv
// Pin function select: serial role switch, interrupt routing, port read source
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps

module pin_function_select
    import pin_function_select_pkg::*;
#(
    parameter int SHARED_W = 2,
    parameter int PERIOD_W = 12
) (
    // Clock and reset
    input  wire logic                            mclk,
    input  wire logic                            reset,
    // Register port
    input  wire reg_req_type                     bus_req,
    output logic [7:0]                           bus_rdata,
    // Shared serial pins
    input  wire logic [SHARED_W-1:0]             shared_pin_in,
    output pin_drive_type [SHARED_W-1:0]         shared_pin_drive,
    // Serial units
    input  wire pin_drive_type [SHARED_W-1:0]    ssu_drive,
    input  wire pin_drive_type [SHARED_W-1:0]    twi_drive,
    output logic [SHARED_W-1:0]                  ssu_pin_in,
    output logic [SHARED_W-1:0]                  twi_pin_in,
    // Interrupt one candidate pins and routed input
    input  wire logic                            irq_pin_p1_7,
    input  wire logic                            irq_pin_p1_5,
    input  wire logic                            irq_pin_p2_0,
    output logic                                 external_irq_one_n,
    // Port read path
    input  wire logic [PORT_COUNT*PORT_WIDTH-1:0] port_pin_level,
    input  wire logic [PORT_COUNT*PORT_WIDTH-1:0] port_latch,
    input  wire logic [PORT_COUNT*PORT_WIDTH-1:0] port_direction_reg,
    output logic [PORT_COUNT*PORT_WIDTH-1:0]      port_read_value,
    // Two-wire rate
    input  wire logic [PERIOD_W-1:0]             twi_base_period,
    output logic [PERIOD_W:0]                    twi_rate_period,
    output logic                                 twi_rate_tick
);

    localparam int PORT_BITS = PORT_COUNT * PORT_WIDTH;
    localparam int SYNC_W    = SHARED_W + 3 + PORT_BITS;
    localparam int EXEMPT_IX = EXEMPT_PORT * PORT_WIDTH + EXEMPT_BIT;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic port_bit_read(input logic src, input logic dir,
                                           input logic pin, input logic latch);
        return (src || !dir) ? pin : latch;
    endfunction

    // Forbidden codes leave the interrupt input idle rather than picking a pin
    function automatic logic route_irq(input logic [2:0] code, input logic p17,
                                       input logic p15, input logic p20);
        if (code == IRQ_FROM_P1_7) begin
            return p17;
        end else if (code == IRQ_FROM_P1_5) begin
            return p15;
        end else if (code == IRQ_FROM_P2_0) begin
            return p20;
        end
        return 1'b1;
    endfunction

    // Both bits set is undefined; we keep the divider rate then
    function automatic logic [PERIOD_W:0] rate_period(input logic dbl, input logic half,
                                                      input logic [PERIOD_W-1:0] base);
        logic [PERIOD_W:0] p;
        p = {1'b0, base};
        if (dbl && !half) begin
            p = p >> 1;
            if (p == '0 && base != '0) begin
                p = (PERIOD_W+1)'(1);
            end
        end else if (half && !dbl) begin
            p = {base, 1'b0};
        end
        return p;
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;

    always_ff @(posedge mclk) begin
        if (reset) begin
            sync1_ff <= '1;
            sync2_ff <= '1;
        end else begin
            sync1_ff <= {shared_pin_in, irq_pin_p1_7, irq_pin_p1_5, irq_pin_p2_0,
                         port_pin_level};
            sync2_ff <= sync1_ff;
        end
    end

    logic [SHARED_W-1:0]  shared_sync;
    logic                 p17_sync;
    logic                 p15_sync;
    logic                 p20_sync;
    logic [PORT_BITS-1:0] pin_sync;

    assign {shared_sync, p17_sync, p15_sync, p20_sync, pin_sync} = sync2_ff;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] serial_role_switch_ff;
    logic [7:0] interrupt_pin_route_ff;
    logic [7:0] io_function_route_ff;

    // Masking on write keeps unassigned bits at zero for good
    always_ff @(posedge mclk) begin
        if (reset) begin
            serial_role_switch_ff <= SERIAL_ROLE_SWITCH_RST;
        end else if (bus_req.wr && bus_req.addr == SERIAL_ROLE_SWITCH_OFS) begin
            serial_role_switch_ff <= bus_req.wdata & SERIAL_ROLE_SWITCH_MASK;
        end
    end

    // Routing is not guarded against change in flight; software must hold it
    always_ff @(posedge mclk) begin
        if (reset) begin
            interrupt_pin_route_ff <= INTERRUPT_PIN_ROUTE_RST;
        end else if (bus_req.wr && bus_req.addr == INTERRUPT_PIN_ROUTE_OFS) begin
            interrupt_pin_route_ff <= bus_req.wdata & INTERRUPT_PIN_ROUTE_MASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            io_function_route_ff <= IO_FUNCTION_ROUTE_RST;
        end else if (bus_req.wr && bus_req.addr == IO_FUNCTION_ROUTE_OFS) begin
            io_function_route_ff <= bus_req.wdata & IO_FUNCTION_ROUTE_MASK;
        end
    end

    logic       serial_role_select;
    logic [2:0] irq_route;
    logic       port_read_source;
    logic       twi_rate_double;
    logic       twi_rate_half;
    logic [1:0] data_line_delay;

    assign serial_role_select = serial_role_switch_ff[SERIAL_ROLE_SELECT_POS];
    assign irq_route          = interrupt_pin_route_ff[IRQ_ROUTE_MSB:IRQ_ROUTE_LSB];
    assign port_read_source   = io_function_route_ff[PORT_READ_SOURCE_POS];
    assign twi_rate_double    = io_function_route_ff[TWI_RATE_DOUBLE_POS];
    assign twi_rate_half      = io_function_route_ff[TWI_RATE_HALF_POS];
    assign data_line_delay    = io_function_route_ff[DATA_DELAY_MSB:DATA_DELAY_LSB];

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    logic [7:0] rdata_ff;

    // Data stand for one cycle only; unmapped reads return zero
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_ff <= 8'h00;
        end else if (!bus_req.rd) begin
            rdata_ff <= 8'h00;
        end else if (bus_req.addr == SERIAL_ROLE_SWITCH_OFS) begin
            rdata_ff <= serial_role_switch_ff;
        end else if (bus_req.addr == INTERRUPT_PIN_ROUTE_OFS) begin
            rdata_ff <= interrupt_pin_route_ff;
        end else if (bus_req.addr == IO_FUNCTION_ROUTE_OFS) begin
            rdata_ff <= io_function_route_ff;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign bus_rdata = rdata_ff;

    // ----------------------------------------------------------------
    // Shared pin switch
    // ----------------------------------------------------------------
    pin_drive_type [SHARED_W-1:0] twi_delayed;
    pin_drive_type [SHARED_W-1:0] pin_drive_ff;
    pin_drive_type                sda_delayed;

    // Only the data line is delayed; the clock line passes straight through
    always_comb begin
        twi_delayed = twi_drive;
        twi_delayed[TWI_SDA_IDX] = sda_delayed;
    end

    // Data line takes the delay line, so its total lag matches the code
    sda_delay_line #(
        .DEPTH (SDA_DELAY_LONG)
    ) u_sda_delay (
        .mclk  (mclk),
        .reset (reset),
        .din   (twi_drive[TWI_SDA_IDX]),
        .code  (data_line_delay),
        .dout  (sda_delayed)
    );

    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_drive_ff <= {SHARED_W{PIN_RELEASED}};
        end else if (serial_role_select) begin
            pin_drive_ff <= twi_delayed;
        end else begin
            pin_drive_ff <= ssu_drive;
        end
    end

    assign shared_pin_drive = pin_drive_ff;
    // The unit that lost the pins sees an idle-high line
    assign ssu_pin_in = serial_role_select ? '1 : shared_sync;
    assign twi_pin_in = serial_role_select ? shared_sync : '1;

    // ----------------------------------------------------------------
    // Interrupt one routing
    // ----------------------------------------------------------------
    logic irq_one_ff;

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_one_ff <= 1'b1;
        end else begin
            irq_one_ff <= route_irq(irq_route, p17_sync, p15_sync, p20_sync);
        end
    end

    assign external_irq_one_n = irq_one_ff;

    // ----------------------------------------------------------------
    // Port read source
    // ----------------------------------------------------------------
    logic [PORT_BITS-1:0] port_read_ff;

    always_ff @(posedge mclk) begin
        if (reset) begin
            port_read_ff <= '0;
        end else begin
            for (int i = 0; i < PORT_BITS; i++) begin
                port_read_ff[i] <= port_bit_read((i == EXEMPT_IX) ? 1'b0 : port_read_source,
                                                 port_direction_reg[i], pin_sync[i],
                                                 port_latch[i]);
            end
        end
    end

    assign port_read_value = port_read_ff;

    // ----------------------------------------------------------------
    // Two-wire rate
    // ----------------------------------------------------------------
    logic [PERIOD_W:0] period_ff;
    logic [PERIOD_W:0] rate_cnt_ff;
    logic              tick_ff;

    always_ff @(posedge mclk) begin
        if (reset) begin
            period_ff <= '0;
        end else begin
            period_ff <= rate_period(twi_rate_double, twi_rate_half,
                                     twi_base_period);
        end
    end

    // A zero period halts the tick rather than wrapping the counter
    always_ff @(posedge mclk) begin
        if (reset || period_ff == '0) begin
            rate_cnt_ff <= '0;
            tick_ff     <= 1'b0;
        end else if (rate_cnt_ff >= period_ff - 1'b1) begin
            rate_cnt_ff <= '0;
            tick_ff     <= 1'b1;
        end else begin
            rate_cnt_ff <= rate_cnt_ff + 1'b1;
            tick_ff     <= 1'b0;
        end
    end

    assign twi_rate_period = period_ff;
    assign twi_rate_tick   = tick_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    sequence short_delay_held;
        (data_line_delay == DELAY_CODE_SHORT && serial_role_select)[*4];
    endsequence

    sequence route_held_p1_5;
        (irq_route == IRQ_FROM_P1_5)[*2];
    endsequence

    role_to_ssu_a: assert property (
        !serial_role_select |=> shared_pin_drive == $past(ssu_drive))
        else $error("shared pins not driven by sync serial unit");

    reserved_zero_a: assert property (
        bus_req.rd && bus_req.addr == SERIAL_ROLE_SWITCH_OFS |=> bus_rdata[7:1] == 7'h00)
        else $error("unassigned switch bits read nonzero");

    irq_route_a: assert property (
        route_held_p1_5 |-> external_irq_one_n == $past(p15_sync))
        else $error("interrupt one not taken from pin 1.5");

    read_by_dir_a: assert property (
        !port_read_source && !port_direction_reg[0] |=> port_read_value[0] == $past(pin_sync[0]))
        else $error("input-mode bit did not read pin level");

    read_latch_a: assert property (
        !port_read_source && port_direction_reg[0] |=> port_read_value[0] == $past(port_latch[0]))
        else $error("output-mode bit did not read latch");

    read_pin_a: assert property (
        port_read_source && port_direction_reg[1] |=> port_read_value[1] == $past(pin_sync[1]))
        else $error("read source 1 did not read pin level");

    exempt_pin_a: assert property (
        port_read_source && port_direction_reg[EXEMPT_IX]
        |=> port_read_value[EXEMPT_IX] == $past(port_latch[EXEMPT_IX]))
        else $error("pin 4.2 followed the read source bit");

    rate_double_a: assert property (
        twi_rate_double && !twi_rate_half && twi_base_period >= 2
        |=> twi_rate_period == ({1'b0, $past(twi_base_period)} >> 1))
        else $error("double rate period wrong");

    rate_half_a: assert property (
        twi_rate_half && !twi_rate_double |=> twi_rate_period == {$past(twi_base_period), 1'b0})
        else $error("half rate period wrong");

    sda_delay_a: assert property (
        short_delay_held |-> shared_pin_drive[TWI_SDA_IDX] == $past(twi_drive[TWI_SDA_IDX], 3))
        else $error("data line delay not three cycles");

    reset_clear_a: assert property (
        $fell(reset) |-> serial_role_switch_ff == 8'h00 && interrupt_pin_route_ff == 8'h00
                         && io_function_route_ff == 8'h00)
        else $error("registers not cleared by reset");

endmodule

// >>> serial_pins_model.sv
// Far-side model: serial units, interrupt pins, port pins and port latches
`timescale 1ns/1ps
module serial_pins_model
    import pin_function_select_pkg::*;
(
    // Clock
    input  wire logic                mclk,
    // Device drive on the shared pins
    input  wire pin_drive_type [1:0] pin_drv,
    // Unit drives and pin levels
    output pin_drive_type [1:0]      ssu_drv,
    output pin_drive_type [1:0]      twi_drv,
    output logic [1:0]               pin_lvl,
    output logic [2:0]               irq,
    output logic [39:0]              lvl,
    output logic [39:0]              lat,
    output logic [39:0]              dir
);
    logic [1:0] ext;

    initial begin
        {ssu_drv, twi_drv, ext, irq} = '0;
        {lvl, lat, dir} = '0;
    end

    // Fresh values every cycle, so a stale level cannot keep passing for a match for long
    always @(posedge mclk) begin
        ssu_drv <= 4'($urandom);
        twi_drv <= 4'($urandom);
        ext <= 2'($urandom);
        irq <= 3'($urandom);
        lvl <= {8'($urandom), $urandom};
        lat <= {8'($urandom), $urandom};
        dir <= {8'($urandom), $urandom};
    end

    // A released pin shows the far side's own level
    assign pin_lvl[0] = pin_drv[0].oe_n ? ext[0] : pin_drv[0].out;
    assign pin_lvl[1] = pin_drv[1].oe_n ? ext[1] : pin_drv[1].out;
endmodule

// >>> test_pin_function_select.sv
// Self-checking bench for the pin function select block
`timescale 1ns/1ps
module test_pin_function_select
    import pin_function_select_pkg::*;
;
    typedef struct packed {
        logic [3:0]  sync_serial_unit;
        logic [3:0]  twi;
        logic [1:0]  pin;
        logic [2:0]  irq;
        logic [39:0] lvl;
        logic [39:0] lat;
        logic [39:0] dir;
        logic [11:0] base;
    } snap_type;

    logic                mclk = 1'b0;
    logic                reset = 1'b1;
    reg_req_type         bus_req = '0;
    logic [7:0]          bus_rdata;
    logic [11:0]         base = 12'h000;
    pin_drive_type [1:0] ssu_drv, twi_drv, pin_drv;
    logic [1:0]          pin_lvl, ssu_in, twi_in;
    logic [2:0]          irq;
    logic                irq_n, tick;
    logic [39:0]         lvl, lat, dir, prv;
    logic [12:0]         period;
    snap_type            h [32];
    int                  cyc = 0;
    int                  mismatches, total_checks, watch, r;
    logic [7:0]          m_role, m_route, m_io;

    initial begin
        forever #2.5 mclk = ~mclk;
    end

    pin_function_select pin_function_select_inst (
        .mclk(mclk), .reset(reset), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .shared_pin_in(pin_lvl), .shared_pin_drive(pin_drv), .ssu_drive(ssu_drv),
        .twi_drive(twi_drv), .ssu_pin_in(ssu_in), .twi_pin_in(twi_in),
        .irq_pin_p1_7(irq[2]), .irq_pin_p1_5(irq[1]), .irq_pin_p2_0(irq[0]),
        .external_irq_one_n(irq_n), .port_pin_level(lvl), .port_latch(lat),
        .port_direction_reg(dir), .port_read_value(prv), .twi_base_period(base),
        .twi_rate_period(period), .twi_rate_tick(tick)
    );

    serial_pins_model serial_pins_model_inst (
        .mclk(mclk), .pin_drv(pin_drv), .ssu_drv(ssu_drv), .twi_drv(twi_drv),
        .pin_lvl(pin_lvl), .irq(irq), .lvl(lvl), .lat(lat), .dir(dir)
    );

    // --------
    // Reference model
    // --------
    function automatic snap_type p(int n);
        return h[(cyc - 1 - n) % 32];
    endfunction

    function automatic int dly(logic [1:0] c);
        return (c == 2'h0) ? SDA_DELAY_SHORT : (c == 2'h1) ? SDA_DELAY_MID : SDA_DELAY_LONG;
    endfunction

    function automatic logic [12:0] rate(logic [11:0] b);
        if (m_io[5:4] == 2'b01) return (b > 1) ? 13'(b >> 1) : 13'(b);
        if (m_io[5:4] == 2'b10) return {b, 1'b0};
        return {1'b0, b};
    endfunction

    task automatic check_port(logic [39:0] got, logic [39:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t pin path got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_bus(logic [7:0] got, logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t read got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_count(int got, int exp);
        total_checks++;
        if (got != exp) begin
            mismatches++;
            $display("MISMATCH t=%0t tick count got %0d exp %0d", $time, got, exp);
        end
    endtask

    always @(posedge mclk) begin
        h[cyc % 32] <= {ssu_drv, twi_drv, pin_lvl, irq, lvl, lat, dir, base};
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            mismatches++;
            results();
        end
    end

    // Pin drive, pin inputs, interrupt, port read and rate period are compared each cycle once the configuration has settled; the tick is not
    always @(negedge mclk) begin : mon
        snap_type s0, s1, s2, sd;
        logic [39:0] e;
        if (watch) begin
            s0 = p(0);
            s1 = p(1);
            s2 = p(2);
            sd = p(dly(m_io[7:6]) - 1);
            e = '0;
            e[1:0] = m_role[0] ? s0.twi[1:0] : s0.sync_serial_unit[1:0];
            e[3:2] = m_role[0] ? sd.twi[3:2] : s0.sync_serial_unit[3:2];
            check_port(pin_drv, e);
            check_port({twi_in, ssu_in}, m_role[0] ? {s1.pin, 2'b11} : {2'b11, s1.pin});
            check_port(irq_n, s2.irq[2 - m_route[3:1]]);
            for (int i = 0; i < 40; i++) begin
                e[i] = (m_io[3] && i != PORT_WIDTH * EXEMPT_PORT + EXEMPT_BIT) ? s2.lvl[i]
                     : (s0.dir[i] ? s0.lat[i] : s2.lvl[i]);
            end
            check_port(prv, e);
            check_port(period, rate(s0.base));
        end
    end

    // --------
    // Bus master and scenarios
    // --------
    task automatic wr(logic [15:0] a, logic [7:0] d);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
        if (a == SERIAL_ROLE_SWITCH_OFS) m_role = d & SERIAL_ROLE_SWITCH_MASK;
        if (a == INTERRUPT_PIN_ROUTE_OFS) m_route = d & INTERRUPT_PIN_ROUTE_MASK;
        if (a == IO_FUNCTION_ROUTE_OFS) m_io = d & IO_FUNCTION_ROUTE_MASK;
        @(posedge mclk);
    endtask

    task automatic rd(logic [15:0] a, logic [7:0] exp);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1 check_bus(bus_rdata, exp);
        @(posedge mclk);
    endtask

    task automatic reg_check();
        rd(SERIAL_ROLE_SWITCH_OFS, m_role);
        rd(INTERRUPT_PIN_ROUTE_OFS, m_route);
        rd(IO_FUNCTION_ROUTE_OFS, m_io);
        rd(16'h018D, 8'h00);
    endtask

    task automatic ticks(int len, int exp);
        int n;
        n = 0;
        repeat (len) begin
            @(negedge mclk);
            n += (tick === 1'b1);
        end
        check_count(n, exp);
        @(posedge mclk);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        {watch, mismatches, total_checks} = '0;
        {m_role, m_route, m_io} = '0;
        void'($urandom(49292));
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        reg_check();
        wr(SERIAL_ROLE_SWITCH_OFS, 8'hFF);
        wr(INTERRUPT_PIN_ROUTE_OFS, 8'hF5);
        wr(IO_FUNCTION_ROUTE_OFS, 8'hAF);
        wr(16'h018D, 8'hFF);
        reg_check();
        $display("register test done");
        // Routing is written before watching and held while it is watched
        for (int i = 0; i < 36; i++) begin
            watch = 0;
            r = $urandom;
            wr(SERIAL_ROLE_SWITCH_OFS, {r[7:1], i[0]});
            wr(INTERRUPT_PIN_ROUTE_OFS, {r[15:12], 3'(i / 2 % 3), r[8]});
            wr(IO_FUNCTION_ROUTE_OFS, {2'(i / 6 % 3), 2'(r[17:16] % 3), i >= 18, r[22:20]});
            rd(IO_FUNCTION_ROUTE_OFS, m_io);
            base <= 12'($urandom);
            repeat (25) @(posedge mclk);
            watch = 1;
            repeat (30) @(posedge mclk);
        end
        watch = 0;
        $display("routing sweep done");
        base <= 12'd10;
        for (int m = 0; m < 3; m++) begin
            wr(IO_FUNCTION_ROUTE_OFS, {2'h0, 2'(m), 4'h0});
            repeat (60) @(posedge mclk);
            ticks(4 * int'(rate(12'd10)), 4);
        end
        base <= 12'd0;
        repeat (5) @(posedge mclk);
        ticks(40, 0);
        $display("rate test done");
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        {m_role, m_route, m_io} = '0;
        @(posedge mclk);
        reg_check();
        $display("mid-run reset test done");
        results();
    end
endmodule
